// ---- rtl/bstp_defs.svh ----
// Constants for the boundary-scan test port.
`ifndef BSTP_DEFS_SVH
`define BSTP_DEFS_SVH
`define BSTP_IR_W          10
`define BSTP_IR_CAPTURE    10'h001
`define BSTP_OP_EXTEST     10'h000
`define BSTP_OP_SAMPLE     10'h005
`define BSTP_OP_IDCODE     10'h006
`define BSTP_OP_CFG_INT    10'h00d
`define BSTP_OP_PULSE_CFG  10'h001
`define BSTP_OP_HIGHZ      10'h00b
`define BSTP_OP_BYPASS     10'h3ff
`define BSTP_IDCODE_RST    32'h0000_0001
`define BSTP_PULSE_NS      1000
`define BSTP_CLK_NS        20
`define BSTP_PULSE_CYC     ((`BSTP_PULSE_NS + `BSTP_CLK_NS - 1) / `BSTP_CLK_NS)
`endif

// ---- rtl/bstp_pkg.sv ----
// Types for the boundary-scan test port.
package bstp_pkg;
    typedef enum logic [3:0] {
        ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h3, ST_CAP_DR = 4'h2,
        ST_SH_DR = 4'h6, ST_EX1_DR = 4'h7, ST_PA_DR = 4'h5, ST_EX2_DR = 4'h4,
        ST_UP_DR = 4'hc, ST_SEL_IR = 4'hd, ST_CAP_IR = 4'hf, ST_SH_IR = 4'he,
        ST_EX1_IR = 4'ha, ST_PA_IR = 4'hb, ST_EX2_IR = 4'h9, ST_UP_IR = 4'h8
    } bstp_state_type;
endpackage : bstp_pkg

// ---- rtl/bstp_tck_if.sv ----
// Interface carrying the sampled test clock events to the controller.
`timescale 1ns/1ns
interface bstp_tck_if;
    logic rise;
    logic fall;
    logic tms;
    logic tdi;
    logic trst_n;
    modport src (output rise, output fall, output tms, output tdi,
                 output trst_n);
    modport dst (input rise, input fall, input tms, input tdi, input trst_n);
endinterface : bstp_tck_if

// ---- rtl/bstp_sync.sv ----
// Two-stage synchronisers and test clock edge finder.
`timescale 1ns/1ns
module bstp_sync (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic tck,
    input  wire logic tms,
    input  wire logic tdi,
    input  wire logic trst_n,
    bstp_tck_if.src   ev
);
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic       tck_old_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            s1_q <= 4'h8;
            s2_q <= 4'h8;
        end else begin
            s1_q <= {trst_n, tdi, tms, tck};
            s2_q <= s1_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tck_old_q <= 1'b0;
        end else begin
            tck_old_q <= s2_q[0];
        end
    end

    assign ev.rise   = s2_q[0] & ~tck_old_q;
    assign ev.fall   = ~s2_q[0] & tck_old_q;
    assign ev.tms    = s2_q[1];
    assign ev.tdi    = s2_q[2];
    assign ev.trst_n = s2_q[3];
endmodule : bstp_sync

// ---- rtl/bstp_tap.sv ----
// Boundary-scan test access port controller with pin scan cells.
`timescale 1ns/1ns
`include "bstp_defs.svh"

// Overview of operation
// - Capture-IR loads a pattern ending in binary 01 so TDO shows 1 then 0.
// - From test-logic-reset, TMS 0,1,1,0,0 lands the controller in Shift-IR.
// - In external test, a pin whose enable cell holds 0 drives its data cell.
// - External test is refused while in-circuit reconfiguration runs.
// - The configuration-interrupt opcode halts configuration and frees I/O.
// - Once configured, differential pins capture the core, not the pad; external test still drives their pads.
// - External test, sample/preload and bypass are all supported.
// - Only bypass, idcode, sample and configuration interrupt run during configuration untouched.
module bstp_tap #(
    parameter int NPINS = 4,
    parameter int PULSE_CYC = `BSTP_PULSE_CYC,
    parameter logic [31:0] IDCODE = `BSTP_IDCODE_RST // Arbitrary value.
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic             tck,
    input  wire logic             tms,
    input  wire logic             tdi,
    input  wire logic             trst_n,
    output logic                  tdo,
    output logic                  tdo_oe,
    input  wire logic             cfg_busy,
    input  wire logic             cfg_done,
    input  wire logic [NPINS-1:0] diff_pin,
    input  wire logic [NPINS-1:0] core_out,
    input  wire logic [NPINS-1:0] core_oe_n,
    input  wire logic [NPINS-1:0] pin_in,
    output logic      [NPINS-1:0] pin_out,
    output logic      [NPINS-1:0] pin_oe,
    output logic                  cfg_halt,
    output logic                  cfg_restart,
    output logic                  extest_active
);
    import bstp_pkg::*;

    if (NPINS < 1 || PULSE_CYC < 1) begin : g_bad_params
        $error("bstp_tap: bad parameters");
    end

    localparam int BSR_W = 2 * NPINS;

    bstp_tck_if ev ();

    bstp_sync u_sync (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .tck     (tck),
        .tms     (tms),
        .tdi     (tdi),
        .trst_n  (trst_n),
        .ev      (ev)
    );

    // ------------------------------------------------------------------
    // Controller
    // ------------------------------------------------------------------
    bstp_state_type st_q;
    bstp_state_type st_d;

    always_comb begin
        case (st_q)
            ST_RESET:  st_d = ev.tms ? ST_RESET  : ST_IDLE;
            ST_IDLE:   st_d = ev.tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: st_d = ev.tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: st_d = ev.tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  st_d = ev.tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: st_d = ev.tms ? ST_UP_DR  : ST_PA_DR;
            ST_PA_DR:  st_d = ev.tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: st_d = ev.tms ? ST_UP_DR  : ST_SH_DR;
            ST_UP_DR:  st_d = ev.tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: st_d = ev.tms ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: st_d = ev.tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  st_d = ev.tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: st_d = ev.tms ? ST_UP_IR  : ST_PA_IR;
            ST_PA_IR:  st_d = ev.tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: st_d = ev.tms ? ST_UP_IR  : ST_SH_IR;
            ST_UP_IR:  st_d = ev.tms ? ST_SEL_DR : ST_IDLE;
            default:   st_d = ST_RESET;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b || !ev.trst_n) begin
            st_q <= ST_RESET;
        end else if (ev.rise) begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------------
    logic [`BSTP_IR_W-1:0] ir_sh_q;
    logic [`BSTP_IR_W-1:0] ir_q;

    // Opcodes other than bypass, idcode, sample and configuration interrupt
    // need configuration halted while it is busy; otherwise they fall back to bypass.
    function automatic logic [`BSTP_IR_W-1:0] gate_op(
        input logic [`BSTP_IR_W-1:0] op,
        input logic                  busy,
        input logic                  halted
    );
        if (busy && !halted && op != `BSTP_OP_BYPASS &&
            op != `BSTP_OP_IDCODE && op != `BSTP_OP_SAMPLE &&
            op != `BSTP_OP_CFG_INT) begin
            return `BSTP_OP_BYPASS;
        end
        return op;
    endfunction : gate_op

    logic halt_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_b || !ev.trst_n) begin
            ir_sh_q <= '0;
            ir_q    <= `BSTP_OP_IDCODE;
        end else if (ev.rise) begin
            if (st_q == ST_CAP_IR) begin
                ir_sh_q <= `BSTP_IR_CAPTURE;
            end else if (st_q == ST_SH_IR) begin
                ir_sh_q <= {ev.tdi, ir_sh_q[`BSTP_IR_W-1:1]};
            end else if (st_q == ST_RESET) begin
                ir_q <= `BSTP_OP_IDCODE;
            end
        end else if (ev.fall && st_q == ST_UP_IR) begin
            ir_q <= gate_op(ir_sh_q, cfg_busy, halt_q);
        end
    end

    // ------------------------------------------------------------------
    // Configuration interaction
    // ------------------------------------------------------------------
    logic [$clog2(PULSE_CYC+1)-1:0] pulse_cnt_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            halt_q      <= 1'b0;
            pulse_cnt_q <= '0;
            cfg_restart <= 1'b0;
            cfg_halt    <= 1'b0;
        end else begin
            if (ir_q == `BSTP_OP_CFG_INT && cfg_busy) begin
                halt_q <= 1'b1;
            end else if (ir_q == `BSTP_OP_PULSE_CFG && halt_q) begin
                halt_q      <= 1'b0;
                pulse_cnt_q <= PULSE_CYC[$bits(pulse_cnt_q)-1:0];
            end
            if (pulse_cnt_q != '0) begin
                pulse_cnt_q <= pulse_cnt_q - 1'b1;
            end
            cfg_restart <= (pulse_cnt_q != '0);
            cfg_halt    <= halt_q;
        end
    end

    // ------------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------------
    logic [BSR_W-1:0] bsr_sh_q;
    logic [BSR_W-1:0] bsr_up_q;
    logic [31:0]      id_sh_q;
    logic             byp_q;
    logic [NPINS-1:0] scan_oe;
    logic [NPINS-1:0] scan_in;

    // Pads are asynchronous to the system clock, so they pass two stages
    // before the capture cells read them.
    logic [NPINS-1:0] pin_s1_q;
    logic [NPINS-1:0] pin_s2_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= pin_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Differential pins of a configured part behave as internal cells:
    // the scan value follows the core, never the pad.
    assign scan_in = (pin_s2_q & ~(diff_pin & {NPINS{cfg_done}})) |
                     (core_out & diff_pin & {NPINS{cfg_done}});
    assign scan_oe = core_oe_n;

    always_ff @(posedge ref_clk) begin
        if (!rst_b || !ev.trst_n) begin
            bsr_sh_q <= '0;
            bsr_up_q <= {BSR_W{1'b1}};
            id_sh_q  <= '0;
            byp_q    <= 1'b0;
        end else if (ev.rise) begin
            if (st_q == ST_CAP_DR) begin
                bsr_sh_q <= {scan_oe, scan_in};
                id_sh_q  <= IDCODE;
                byp_q    <= 1'b0;
            end else if (st_q == ST_SH_DR) begin
                bsr_sh_q <= {ev.tdi, bsr_sh_q[BSR_W-1:1]};
                id_sh_q  <= {ev.tdi, id_sh_q[31:1]};
                byp_q    <= ev.tdi;
            end
        end else if (ev.fall && st_q == ST_UP_DR &&
                     (ir_q == `BSTP_OP_SAMPLE || ir_q == `BSTP_OP_EXTEST)) begin
            bsr_up_q <= bsr_sh_q;
        end
    end

    // ------------------------------------------------------------------
    // Test data output, changed on falling TCK
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b || !ev.trst_n) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (ev.fall) begin
            tdo_oe <= (st_q == ST_SH_IR) || (st_q == ST_SH_DR);
            if (st_q == ST_SH_IR) begin
                tdo <= ir_sh_q[0];
            end else if (ir_q == `BSTP_OP_IDCODE) begin
                tdo <= id_sh_q[0];
            end else if (ir_q == `BSTP_OP_SAMPLE ||
                         ir_q == `BSTP_OP_EXTEST) begin
                tdo <= bsr_sh_q[0];
            end else begin
                tdo <= byp_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pin_out       <= '0;
            pin_oe        <= '0;
            extest_active <= 1'b0;
        end else if (ir_q == `BSTP_OP_EXTEST) begin
            extest_active <= 1'b1;
            pin_out <= bsr_up_q[NPINS-1:0];
            pin_oe  <= ~bsr_up_q[BSR_W-1:NPINS];
        end else if (ir_q == `BSTP_OP_HIGHZ) begin
            extest_active <= 1'b0;
            pin_oe        <= '0;
        end else begin
            extest_active <= 1'b0;
            pin_out       <= core_out;
            pin_oe        <= ~core_oe_n;
        end
    end
endmodule : bstp_tap

// ---- bench/bstp_monitor.sv ----
// Port checks for the boundary-scan test port.
`timescale 1ns/1ns
module bstp_monitor #(
    parameter int NPINS = 4
) (
    input wire logic             ref_clk,
    input wire logic             rst_b,
    input wire logic             tck,
    input wire logic             trst_n,
    input wire logic             tdo,
    input wire logic             tdo_oe,
    input wire logic             cfg_busy,
    input wire logic [NPINS-1:0] pin_out,
    input wire logic             cfg_halt,
    input wire logic             cfg_restart,
    input wire logic             extest_active
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_reset_quiet: assert property ($rose(rst_b) |->
        !tdo_oe && !extest_active && !cfg_halt) else $error("not quiet");
    a_trst_idle: assert property (!trst_n [*6] |->
        !tdo_oe && !extest_active) else $error("trst ignored");
    a_tdo_low_phase: assert property ($changed(tdo) |-> !tck)
        else $error("tdo moved in high phase");
    a_shift_on_fall: assert property ($rose(tdo_oe) |-> !tck)
        else $error("shift output enabled off fall");
    a_pins_on_update: assert property (
        extest_active && $changed(pin_out) |-> !$past(tck, 2))
        else $error("pin moved off update");
    a_extest_not_busy: assert property (
        $rose(extest_active) |-> !cfg_busy || cfg_halt)
        else $error("extest during reconfiguration");
    a_halt_on_update: assert property (
        $rose(cfg_halt) |-> !$past(tck, 3))
        else $error("halt off update");
    a_restart_short: assert property (
        $rose(cfg_restart) |-> ##[1:8] !cfg_restart)
        else $error("restart pulse too long");
endmodule : bstp_monitor

bind bstp_tap bstp_monitor #(.NPINS(NPINS)) u_bstp_monitor (
    .ref_clk(ref_clk), .rst_b(rst_b), .tck(tck), .trst_n(trst_n),
    .tdo(tdo), .tdo_oe(tdo_oe), .cfg_busy(cfg_busy), .pin_out(pin_out),
    .cfg_halt(cfg_halt), .cfg_restart(cfg_restart),
    .extest_active(extest_active));

// ---- bench/bstp_tester.sv ----
// Behavioural boundary-scan tester on the far side of the port.
`timescale 1ns/1ns
module bstp_tester (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst_n,
    input  wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b1;
    end

    // The test clock stands low between steps; tdo is taken at the rise.
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #80;
        o = tdo;
        tck = 1'b1;
        #80;
        tck = 1'b0;
    endtask : step

    // Leaves the controller in test-logic-reset.
    task automatic tap_reset();
        trst_n = 1'b0;
        #400;
        trst_n = 1'b1;
        #160;
    endtask : tap_reset

    task automatic scan(input logic ir, input logic [31:0] din,
                        input int n, output logic [31:0] dout);
        logic o;
        dout = '0;
        step(1'b0, 1'b0, o);
        step(1'b1, 1'b0, o);
        if (ir) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask : scan
endmodule : bstp_tester

// ---- bench/test_boundary_scan_test_port.sv ----
// Self-checking bench for the boundary-scan test port.
`timescale 1ns/1ns
`include "bstp_defs.svh"
module test_boundary_scan_test_port;
    localparam logic [31:0] ID = 32'h0a5c_3e1b; // Arbitrary value.
    logic       ref_clk, rst_b, tck, tms, tdi, trst_n, tdo, tdo_oe;
    logic       cfg_busy, cfg_done, cfg_halt, cfg_restart, extest_active;
    logic [3:0] diff_pin, core_out, core_oe_n, pin_in, pin_out, pin_oe;
    logic [3:0] board;
    int         restart_cyc;
    int         err_total, checks, cyc;
    logic [31:0] d;

    assign pin_in = (pin_out & pin_oe) | (board & ~pin_oe);
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cfg_restart === 1'b1) restart_cyc <= restart_cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            tally_and_finish();
        end
    end

    bstp_tap #(.NPINS(4), .PULSE_CYC(2), .IDCODE(ID)) u_bstp_tap (
        .ref_clk(ref_clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .cfg_busy(cfg_busy),
        .cfg_done(cfg_done), .diff_pin(diff_pin), .core_out(core_out),
        .core_oe_n(core_oe_n), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .cfg_halt(cfg_halt), .cfg_restart(cfg_restart),
        .extest_active(extest_active));
    bstp_tester u_bstp_tester (.tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo(tdo));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic t_capture();
        logic [4:0] walk;
        logic       o1, o0;
        walk = 5'b00110;
        u_bstp_tester.tap_reset();
        for (int i = 0; i < 5; i++) u_bstp_tester.step(walk[i], 1'b0, o1);
        u_bstp_tester.step(1'b0, 1'b0, o1);
        u_bstp_tester.step(1'b0, 1'b0, o0);
        check(o1, 1'b1);
        check(o0, 1'b0);
        check(tdo_oe, 1'b1);
        $display("t_capture done");
    endtask : t_capture

    task automatic t_id_bypass();
        u_bstp_tester.tap_reset();
        u_bstp_tester.scan(1'b0, 32'h0, 32, d);
        check(d, ID);
        u_bstp_tester.scan(1'b1, `BSTP_OP_BYPASS, 10, d);
        check(d[9:0], `BSTP_IR_CAPTURE);
        u_bstp_tester.scan(1'b0, 32'h1, 2, d);
        check(d[1:0], 2'b10);
        $display("t_id_bypass done");
    endtask : t_id_bypass

    task automatic t_extest();
        u_bstp_tester.scan(1'b1, `BSTP_OP_SAMPLE, 10, d);
        u_bstp_tester.scan(1'b0, 32'h59, 8, d);
        check(d[3:0], board);
        u_bstp_tester.scan(1'b1, `BSTP_OP_EXTEST, 10, d);
        check(extest_active, 1'b1);
        check(pin_oe, 4'b1010);
        check(pin_out & 4'b1010, 4'b1000);
        u_bstp_tester.scan(1'b0, 32'h06, 8, d);
        check(d[7:0], 8'hfd);
        check({pin_oe, pin_out}, 8'hf6);
        $display("t_extest done");
    endtask : t_extest

    task automatic t_busy();
        int r0;
        u_bstp_tester.tap_reset();
        @(posedge ref_clk);
        #1 cfg_busy = 1'b1;
        r0 = restart_cyc;
        u_bstp_tester.scan(1'b1, `BSTP_OP_EXTEST, 10, d);
        check(extest_active, 1'b0);
        u_bstp_tester.scan(1'b0, 32'h1, 1, d);
        check(d[0], 1'b0);
        u_bstp_tester.scan(1'b1, `BSTP_OP_IDCODE, 10, d);
        u_bstp_tester.scan(1'b0, 32'h0, 32, d);
        check({cfg_halt, d}, {1'b0, ID});
        u_bstp_tester.scan(1'b1, `BSTP_OP_CFG_INT, 10, d);
        check(cfg_halt, 1'b1);
        check(restart_cyc - r0, 0);
        u_bstp_tester.scan(1'b1, `BSTP_OP_EXTEST, 10, d);
        check(extest_active, 1'b1);
        u_bstp_tester.scan(1'b1, `BSTP_OP_PULSE_CFG, 10, d);
        check({cfg_halt, extest_active}, 2'b00);
        check(restart_cyc - r0, 2);
        $display("t_busy done");
    endtask : t_busy

    task automatic t_config();
        cfg_busy = 1'b1;
        cfg_done = 1'b1;
        diff_pin = 4'b0011;
        core_out = 4'b0101;
        u_bstp_tester.scan(1'b1, `BSTP_OP_SAMPLE, 10, d);
        u_bstp_tester.scan(1'b0, 32'h0, 8, d);
        check(d[7:0], 8'hf5);
        core_oe_n = 4'h0;
        u_bstp_tester.scan(1'b1, `BSTP_OP_HIGHZ, 10, d);
        check(pin_oe, 4'hf);
        cfg_busy = 1'b0;
        u_bstp_tester.scan(1'b1, `BSTP_OP_HIGHZ, 10, d);
        check(pin_oe, 4'h0);
        $display("t_config done");
    endtask : t_config

    initial begin
        {ref_clk, rst_b, cfg_busy, cfg_done} = '0;
        {diff_pin, core_out, core_oe_n, board} = 16'h00f7;
        {err_total, checks, cyc, restart_cyc} = '0;
        repeat (10) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        t_capture();
        t_id_bypass();
        t_extest();
        t_busy();
        t_config();
        tally_and_finish();
    end
endmodule : test_boundary_scan_test_port
